// *** rtl/motor_status_pkg.sv ***
// Constants shared by the motor status and position register block
package motor_status_pkg;

	// ------------------------------------------------------------
	// Register map (word offsets on the plain register port)
	// ------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFS_HOLD_M1 = 5'h00;
	localparam logic [4:0] OFS_NOM_M1 = 5'h01;
	localparam logic [4:0] OFS_MAX_M1 = 5'h02;
	localparam logic [4:0] OFS_HOLD_M2 = 5'h03;
	localparam logic [4:0] OFS_NOM_M2 = 5'h04;
	localparam logic [4:0] OFS_MAX_M2 = 5'h05;
	localparam logic [4:0] OFS_FAULT_STATUS = 5'h06;
	localparam logic [4:0] OFS_FAULT_ACK = 5'h07;
	localparam logic [4:0] OFS_POS_CYC_CH1 = 5'h08;
	localparam logic [4:0] OFS_POS_CYC_CH2 = 5'h09;
	localparam logic [4:0] OFS_POS_ACYC_CH1 = 5'h0A;
	localparam logic [4:0] OFS_POS_ACYC_CH2 = 5'h0B;
	localparam logic [4:0] OFS_COUNTER_CFG = 5'h0C;
	localparam logic [4:0] OFS_MODULE_CFG = 5'h0D;
	localparam logic [4:0] OFS_MOTION_CTRL = 5'h0E;
	localparam logic [4:0] OFS_CURRENT_SEL = 5'h0F;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ERR_STALL = 0;
	localparam int ERR_HEAT = 1;
	localparam int ERR_SHORTFALL = 2;
	localparam int ERR_EXCESS = 3;
	localparam int ERR_M2_BASE = 4;
	localparam int ERR_SUPPLY_A = 8;
	localparam int ERR_HEALTHY_1 = 9;
	localparam int ERR_SUPPLY_B = 12;
	localparam int ERR_HEALTHY_2 = 13;
	localparam int CCFG_SWAP_CH1 = 3;
	localparam int CCFG_SWAP_CH2 = 7;
	localparam int MCFG_USTEP_LO = 5;
	localparam int ACK_M1 = 0;
	localparam int ACK_M2 = 1;
	// Motion control register: bit0 step m1, bit2 dir m1, bit4 step m2, bit6 dir m2
	localparam int MCTL_STEP = 0;
	localparam int MCTL_DIR = 2;

	// ------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------
	localparam logic [7:0] HOLD_RESET = 8'h00;
	localparam logic [7:0] NOM_RESET = 8'h00;
	localparam logic [7:0] MAX_RESET = 8'h00;
	localparam logic [15:0] POS_RESET = 16'h0000;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [1:0] USTEP_5 = 2'h0;
	localparam logic [1:0] USTEP_6 = 2'h1;
	localparam logic [1:0] USTEP_7 = 2'h2;
	localparam logic [1:0] USTEP_8 = 2'h3;
	// Lowest set weight at 1/64 full step for microstep widths 7 and 8
	localparam logic [15:0] MASK_USTEP_7 = 16'hFFFE;
	localparam logic [15:0] MASK_USTEP_8 = 16'hFFFC;

	typedef enum logic [1:0] {
		CUR_HOLD,
		CUR_NOMINAL,
		CUR_MAXIMUM
	} current_sel_e;

endpackage

// *** rtl/fault_latch.sv ***
// Sticky fault flags for one motor with acknowledge
`timescale 1ns/1ps
module fault_latch
	import motor_status_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Raw fault conditions: stall, overheat, shortfall, excess
	input wire logic [3:0] fault_raw,
	// Acknowledge pulse
	input wire logic ack,
	// Latched flags
	output logic [3:0] flags
);

	// Raw faults win over the acknowledge, so a live fault re-sets at once
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flags <= 4'h0;
		end else if (ack) begin
			flags <= fault_raw;
		end else begin
			flags <= flags | fault_raw;
		end
	end

endmodule

// *** rtl/position_counter.sv ***
// Cyclic 16-bit up/down counter for one position channel
`timescale 1ns/1ps
module position_counter
	import motor_status_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Count request and direction (1 = down)
	input wire logic step,
	input wire logic dir_down,
	// Counter value
	output logic [15:0] count
);

	// Wraps freely in both directions
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count <= POS_RESET;
		end else if (step) begin
			count <= dir_down ? count - 16'h0001 : count + 16'h0001;
		end
	end

endmodule

// *** rtl/motor_status_position_regs.sv ***
// Motor status, fault and position readback register block
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module motor_status_position_regs
	import motor_status_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Configured current values from the configuration block
	input wire logic [7:0] hold_cfg_m1,
	input wire logic [7:0] nom_cfg_m1,
	input wire logic [7:0] max_cfg_m1,
	input wire logic [7:0] hold_cfg_m2,
	input wire logic [7:0] nom_cfg_m2,
	input wire logic [7:0] max_cfg_m2,
	// Motion state per motor
	input wire logic [1:0] motor_accel,
	input wire logic [1:0] motor_standstill,
	// Fault detector pins, per motor and shared
	input wire logic [1:0] stall_det,
	input wire logic [1:0] stage_overtemp,
	input wire logic module_overtemp,
	input wire logic [1:0] current_shortfall,
	input wire logic [1:0] excess_current,
	input wire logic supply_under,
	input wire logic supply_over,
	// Drive readiness conditions per motor
	input wire logic [1:0] motor_on,
	input wire logic [1:0] ground_check_ok,
	input wire logic [1:0] motor_ident_done,
	input wire logic [1:0] motor_energized,
	input wire logic [1:0] settling_done,
	input wire logic [1:0] preset_pos_valid,
	// Encoder count pins per channel
	input wire logic [1:0] enc_step,
	input wire logic [1:0] enc_dir_down,
	// Model selection
	input wire logic nc_function_model,
	input wire logic drive_feedback_info,
	// Applied current level per motor
	output logic [1:0] current_sel_m1,
	output logic [1:0] current_sel_m2,
	output logic [7:0] applied_current_m1,
	output logic [7:0] applied_current_m2
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Pack order must match the unpack order below
	localparam int SYNC_W = 31;
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;

	assign pins_raw = {motor_accel, motor_standstill, stall_det, stage_overtemp,
		module_overtemp, current_shortfall, excess_current, supply_under, supply_over,
		motor_on, ground_check_ok, motor_ident_done, motor_energized, settling_done,
		preset_pos_valid, enc_step, enc_dir_down};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
		end
	end

	logic [1:0] s_accel, s_still, s_stall, s_stage_hot, s_short, s_excess;
	logic [1:0] s_on, s_gnd, s_ident, s_energ, s_settle, s_preset, s_enc_step, s_enc_dn;
	logic s_mod_hot, s_under, s_over;

	assign {s_accel, s_still, s_stall, s_stage_hot, s_mod_hot, s_short, s_excess,
		s_under, s_over, s_on, s_gnd, s_ident, s_energ, s_settle, s_preset,
		s_enc_step, s_enc_dn} = sync2_reg;

	// ------------------------------------------------------------
	// Software control registers
	// ------------------------------------------------------------
	logic [7:0] counter_cfg_reg;
	logic [7:0] module_cfg_reg;
	logic wr_motion;
	logic [7:0] motion_wdata;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			counter_cfg_reg <= CFG_RESET;
			module_cfg_reg <= CFG_RESET;
		end else if (reg_wr) begin
			if (reg_addr == OFS_COUNTER_CFG) begin
				counter_cfg_reg <= reg_wdata[7:0];
			end
			if (reg_addr == OFS_MODULE_CFG) begin
				module_cfg_reg <= reg_wdata[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Motion setpoint strobe
	// ------------------------------------------------------------

	// Setpoint steps come from software writes, one step per write
	assign wr_motion = reg_wr && (reg_addr == OFS_MOTION_CTRL);
	assign motion_wdata = reg_wdata[7:0];

	// ------------------------------------------------------------
	// Current selection
	// ------------------------------------------------------------
	function automatic logic [1:0] pick_level(input logic accel, input logic still);
		if (accel) begin
			pick_level = 2'(CUR_MAXIMUM);
		end else if (still) begin
			pick_level = 2'(CUR_HOLD);
		end else begin
			pick_level = 2'(CUR_NOMINAL);
		end
	endfunction

	function automatic logic [7:0] pick_value(input logic [1:0] sel, input logic [7:0] h,
		input logic [7:0] n, input logic [7:0] m);
		case (sel)
			2'(CUR_HOLD): pick_value = h;
			2'(CUR_MAXIMUM): pick_value = m;
			default: pick_value = n;
		endcase
	endfunction

	// Acceleration takes priority if a move starts from standstill
	logic [1:0] level_m1, level_m2;

	assign level_m1 = pick_level(s_accel[0], s_still[0]);
	assign level_m2 = pick_level(s_accel[1], s_still[1]);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			current_sel_m1 <= 2'(CUR_HOLD);
			current_sel_m2 <= 2'(CUR_HOLD);
			applied_current_m1 <= HOLD_RESET;
			applied_current_m2 <= HOLD_RESET;
		end else begin
			current_sel_m1 <= level_m1;
			current_sel_m2 <= level_m2;
			applied_current_m1 <= pick_value(level_m1, hold_cfg_m1, nom_cfg_m1, max_cfg_m1);
			applied_current_m2 <= pick_value(level_m2, hold_cfg_m2, nom_cfg_m2, max_cfg_m2);
		end
	end

	// ------------------------------------------------------------
	// Fault flags
	// ------------------------------------------------------------
	logic supply_fault;
	logic [7:0] fault_raw;
	logic [7:0] fault_flags;
	logic [1:0] ack;
	logic [1:0] healthy;

	assign supply_fault = s_under | s_over;
	assign ack[0] = reg_wr && (reg_addr == OFS_FAULT_ACK) && reg_wdata[ACK_M1];
	assign ack[1] = reg_wr && (reg_addr == OFS_FAULT_ACK) && reg_wdata[ACK_M2];

	// Module overtemperature is shared, so it raises both motors' flags
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_motor
			assign fault_raw[g*ERR_M2_BASE + ERR_STALL] = s_stall[g];
			assign fault_raw[g*ERR_M2_BASE + ERR_HEAT] = s_stage_hot[g] | s_mod_hot;
			assign fault_raw[g*ERR_M2_BASE + ERR_SHORTFALL] = s_short[g];
			assign fault_raw[g*ERR_M2_BASE + ERR_EXCESS] = s_excess[g];

			fault_latch u_latch (
				.clk_sys(clk_sys),
				.rst(rst),
				.fault_raw(fault_raw[g*ERR_M2_BASE +: 4]),
				.ack(ack[g]),
				.flags(fault_flags[g*ERR_M2_BASE +: 4])
			);

			// Raw overheat, not the latched flag, so healthy returns once it cools
			assign healthy[g] = s_on[g] & s_gnd[g] & s_ident[g] & s_energ[g] & s_settle[g]
				& ~supply_fault & ~fault_raw[g*ERR_M2_BASE + ERR_HEAT]
				& s_preset[g];
		end
	endgenerate

	// ------------------------------------------------------------
	// Status word
	// ------------------------------------------------------------
	logic [15:0] status_word;

	always_comb begin
		// Standard model has no supply bits and floods the word on a supply fault
		status_word = 16'h0000;
		status_word[7:0] = fault_flags;
		if (nc_function_model) begin
			status_word[ERR_SUPPLY_A] = supply_fault;
			status_word[ERR_SUPPLY_B] = supply_fault;
			if (drive_feedback_info) begin
				status_word[ERR_HEALTHY_1] = healthy[0];
				status_word[ERR_HEALTHY_2] = healthy[1];
			end
		end else if (supply_fault) begin
			status_word = 16'hFFFF;
		end
	end

	// ------------------------------------------------------------
	// Position counters
	// ------------------------------------------------------------
	logic [15:0] setpoint_ch1, setpoint_ch2;
	logic [15:0] enc_ch1, enc_ch2;

	position_counter u_set1 (
		.clk_sys(clk_sys),
		.rst(rst),
		.step(wr_motion && motion_wdata[MCTL_STEP]),
		.dir_down(motion_wdata[MCTL_DIR]),
		.count(setpoint_ch1)
	);
	position_counter u_set2 (
		.clk_sys(clk_sys),
		.rst(rst),
		.step(wr_motion && motion_wdata[MCTL_STEP+4]),
		.dir_down(motion_wdata[MCTL_DIR+4]),
		.count(setpoint_ch2)
	);
	// Encoder counts follow the synced pins, one count per high cycle
	position_counter u_enc1 (
		.clk_sys(clk_sys),
		.rst(rst),
		.step(s_enc_step[0]),
		.dir_down(s_enc_dn[0]),
		.count(enc_ch1)
	);
	position_counter u_enc2 (
		.clk_sys(clk_sys),
		.rst(rst),
		.step(s_enc_step[1]),
		.dir_down(s_enc_dn[1]),
		.count(enc_ch2)
	);

	// ------------------------------------------------------------
	// Microstep masking
	// ------------------------------------------------------------
	// Microstep width 5..8 bits; finest real step is 1/64 full step
	logic [1:0] ustep_sel;
	logic [15:0] fine_mask;

	assign ustep_sel = module_cfg_reg[MCFG_USTEP_LO +: 2];

	always_comb begin
		case (ustep_sel)
			USTEP_7: fine_mask = MASK_USTEP_7;
			USTEP_8: fine_mask = MASK_USTEP_8;
			default: fine_mask = 16'hFFFF;
		endcase
	end

	logic [15:0] int_pos_ch1, int_pos_ch2;
	assign int_pos_ch1 = setpoint_ch1 & fine_mask;
	assign int_pos_ch2 = setpoint_ch2 & fine_mask;

	// ------------------------------------------------------------
	// Position source select
	// ------------------------------------------------------------
	// Encoder counts are passed raw; only the internal setpoint is masked
	logic [15:0] pos_cyc1, pos_cyc2, pos_acyc1, pos_acyc2;
	assign pos_cyc1 = counter_cfg_reg[CCFG_SWAP_CH1] ? enc_ch1 : int_pos_ch1;
	assign pos_acyc1 = counter_cfg_reg[CCFG_SWAP_CH1] ? int_pos_ch1 : enc_ch1;
	assign pos_cyc2 = counter_cfg_reg[CCFG_SWAP_CH2] ? enc_ch2 : int_pos_ch2;
	assign pos_acyc2 = counter_cfg_reg[CCFG_SWAP_CH2] ? int_pos_ch2 : enc_ch2;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	// Unmapped and write-only offsets read as zero
	logic [15:0] rd_value;

	always_comb begin
		case (reg_addr)
			OFS_HOLD_M1: rd_value = {8'h00, hold_cfg_m1};
			OFS_NOM_M1: rd_value = {8'h00, nom_cfg_m1};
			OFS_MAX_M1: rd_value = {8'h00, max_cfg_m1};
			OFS_HOLD_M2: rd_value = {8'h00, hold_cfg_m2};
			OFS_NOM_M2: rd_value = {8'h00, nom_cfg_m2};
			OFS_MAX_M2: rd_value = {8'h00, max_cfg_m2};
			// Status reads live; flags clear only through the acknowledge register
			OFS_FAULT_STATUS: rd_value = status_word;
			OFS_POS_CYC_CH1: rd_value = pos_cyc1;
			OFS_POS_CYC_CH2: rd_value = pos_cyc2;
			OFS_POS_ACYC_CH1: rd_value = pos_acyc1;
			OFS_POS_ACYC_CH2: rd_value = pos_acyc2;
			OFS_COUNTER_CFG: rd_value = {8'h00, counter_cfg_reg};
			OFS_MODULE_CFG: rd_value = {8'h00, module_cfg_reg};
			OFS_CURRENT_SEL: rd_value = {4'h0, applied_current_m2[7:6], current_sel_m2,
				4'h0, applied_current_m1[7:6], current_sel_m1};
			default: rd_value = 16'h0000;
		endcase
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= rd_value;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

endmodule

// *** bench/motor_status_position_regs_props.sv ***
// Port-level assertions for the motor status and position register block
`timescale 1ns/1ps
module motor_status_props
	import motor_status_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Watched pins
	input wire logic [7:0] hold_cfg_m1,
	input wire logic [1:0] motor_accel,
	input wire logic [1:0] motor_standstill,
	input wire logic [1:0] stall_det,
	input wire logic supply_under,
	input wire logic [1:0] motor_on,
	input wire logic nc_function_model,
	input wire logic drive_feedback_info,
	input wire logic [1:0] current_sel_m1
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Pins pass a two-stage sync, so every synced-pin antecedent holds four cycles
	wire logic rd_st = reg_rd && reg_addr == OFS_FAULT_STATUS;
	wire logic nc_fb = nc_function_model && drive_feedback_info;

	chk_hold_readback: assert property (reg_rd && reg_addr == OFS_HOLD_M1 |=>
		reg_rdata == {8'h00, $past(hold_cfg_m1)}) else $error("hold readback wrong");
	chk_accel_max: assert property (motor_accel[0] [*4] |=> current_sel_m1 == 2'h2)
		else $error("maximum current not selected");
	chk_still_hold: assert property ((motor_standstill[0] && !motor_accel[0]) [*4] |=>
		current_sel_m1 == 2'h0) else $error("holding current not selected");
	chk_stall_latched: assert property (stall_det[0] [*4] ##1 rd_st |=> reg_rdata[0])
		else $error("stall flag missing");
	chk_reserved_zero: assert property (rd_st && nc_function_model |=>
		reg_rdata[15:14] == 2'h0 && reg_rdata[11:10] == 2'h0) else $error("reserved bit set");
	chk_std_all_ones: assert property ((!nc_function_model && supply_under) [*4] ##1
		(!nc_function_model && supply_under && rd_st) |=> reg_rdata == 16'hFFFF)
		else $error("standard supply word wrong");
	chk_supply_flags: assert property ((nc_function_model && supply_under) [*4] ##1
		(nc_function_model && supply_under && rd_st) |=> reg_rdata[8] && reg_rdata[12])
		else $error("supply flags missing");
	chk_healthy_off: assert property ((nc_fb && !motor_on[0]) [*4] ##1 (nc_fb && rd_st) |=>
		!reg_rdata[9]) else $error("healthy set while motor off");
	chk_ack_reads_zero: assert property (reg_rd && reg_addr == OFS_FAULT_ACK |=>
		reg_rdata == 16'h0000) else $error("acknowledge register read nonzero");

	cover property (rd_st ##1 reg_rdata == 16'hFFFF);
	cover property (motor_accel[0] ##1 current_sel_m1 == 2'h2);
	cover property (rd_st ##1 reg_rdata[0]);
endmodule

bind motor_status_position_regs motor_status_props i_props (.clk_sys(clk_sys), .rst(rst),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hold_cfg_m1(hold_cfg_m1),
	.motor_accel(motor_accel), .motor_standstill(motor_standstill), .stall_det(stall_det),
	.supply_under(supply_under), .motor_on(motor_on), .nc_function_model(nc_function_model),
	.drive_feedback_info(drive_feedback_info), .current_sel_m1(current_sel_m1));

// *** bench/motor_status_position_regs_tb_top.sv ***
// Self-checking bench for the motor status and position register block
`timescale 1ns/1ps
module motor_status_position_regs_tb_top import motor_status_pkg::*; ();
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [7:0] cfg [6] = '{8'h00, 8'h64, 8'hFF, 8'h1E, 8'h50, 8'hA7};
	logic [15:0] msk [4] = '{16'hFFFF, 16'hFFFF, 16'hFFFE, 16'hFFFC};
	logic [1:0] accel = 2'h0, still = 2'h0, enc_step = 2'h0, enc_dir = 2'h0;
	logic [7:0] fr = 8'h00;
	logic [11:0] hc = 12'hFFF;
	logic mod_hot = 1'b0, s_under = 1'b0, s_over = 1'b0, nc = 1'b1, fb = 1'b1;
	logic [1:0] sel1, sel2;
	logic [7:0] cur1, cur2;
	int miscompares = 0, total_checks = 0, cycles = 0;

	always #25 clk_sys = ~clk_sys;

	motor_status_position_regs i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.hold_cfg_m1(cfg[0]), .nom_cfg_m1(cfg[1]), .max_cfg_m1(cfg[2]),
		.hold_cfg_m2(cfg[3]), .nom_cfg_m2(cfg[4]), .max_cfg_m2(cfg[5]),
		.motor_accel(accel), .motor_standstill(still), .stall_det(fr[1:0]),
		.stage_overtemp(fr[3:2]), .module_overtemp(mod_hot), .current_shortfall(fr[5:4]),
		.excess_current(fr[7:6]), .supply_under(s_under), .supply_over(s_over),
		.motor_on(hc[1:0]), .ground_check_ok(hc[3:2]), .motor_ident_done(hc[5:4]),
		.motor_energized(hc[7:6]), .settling_done(hc[9:8]), .preset_pos_valid(hc[11:10]),
		.enc_step(enc_step), .enc_dir_down(enc_dir), .nc_function_model(nc),
		.drive_feedback_info(fb), .current_sel_m1(sel1), .current_sel_m2(sel2),
		.applied_current_m1(cur1), .applied_current_m2(cur2));

	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Sampled just after the edge so the registered data has landed
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		logic [1:0] e;
		wait_cyc(4);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++)
			rd(OFS_HOLD_M1 + 5'(i), {8'h00, cfg[i]});
		wr(OFS_HOLD_M1, 16'h00AA);
		rd(OFS_HOLD_M1, 16'h0000);
		rd(5'h1F, 16'h0000);
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_sys) accel <= {2{s[0]}};
			still <= {2{s[1]}};
			wait_cyc(5);
			e = s[0] ? 2'h2 : (s[1] ? 2'h0 : 2'h1);
			#1 chk({12'h000, sel2, sel1}, {12'h000, e, e});
			chk({cur2, cur1}, {cfg[3 + e], cfg[e]});
		end
		rd(OFS_FAULT_STATUS, 16'h2200);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk_sys) fr <= 8'(1 << (2 * (k % 4) + k / 4));
			wait_cyc(4);
			@(posedge clk_sys) fr <= 8'h00;
			wait_cyc(4);
			rd(OFS_FAULT_STATUS, 16'h2200 | 16'(1 << k));
			wr(OFS_FAULT_ACK, 16'(k < 4 ? 2 : 1));
			rd(OFS_FAULT_STATUS, 16'h2200 | 16'(1 << k));
			wr(OFS_FAULT_ACK, 16'(k < 4 ? 1 : 2));
			rd(OFS_FAULT_STATUS, 16'h2200);
		end
		@(posedge clk_sys) mod_hot <= 1'b1;
		wait_cyc(4);
		@(posedge clk_sys) mod_hot <= 1'b0;
		wait_cyc(4);
		rd(OFS_FAULT_STATUS, 16'h2222);
		wr(OFS_FAULT_ACK, 16'h0003);
		@(posedge clk_sys) fr <= 8'h01;
		wait_cyc(4);
		wr(OFS_FAULT_ACK, 16'h0001);
		rd(OFS_FAULT_STATUS, 16'h2201);
		@(posedge clk_sys) fr <= 8'h00;
		wait_cyc(4);
		wr(OFS_FAULT_ACK, 16'h0001);
		rd(OFS_FAULT_STATUS, 16'h2200);
		for (int c = 0; c < 6; c++) begin
			@(posedge clk_sys) hc <= ~(12'h001 << (2 * c));
			wait_cyc(4);
			rd(OFS_FAULT_STATUS, 16'h2000);
		end
		@(posedge clk_sys) hc <= 12'hFFF;
		fb <= 1'b0;
		wait_cyc(4);
		rd(OFS_FAULT_STATUS, 16'h0000);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_sys) {s_over, s_under} <= 2'(1 << v);
			nc <= 1'b1;
			fb <= 1'b1;
			wait_cyc(4);
			rd(OFS_FAULT_STATUS, 16'h1100);
			@(posedge clk_sys) nc <= 1'b0;
			wait_cyc(4);
			rd(OFS_FAULT_STATUS, 16'hFFFF);
			@(posedge clk_sys) {s_over, s_under} <= 2'h0;
			wait_cyc(4);
			rd(OFS_FAULT_STATUS, 16'h0000);
		end
		@(posedge clk_sys) nc <= 1'b1;
		// Internal ch1 steps down from zero and must wrap
		wr(OFS_MOTION_CTRL, 16'h0005);
		rd(OFS_POS_CYC_CH1, 16'hFFFF);
		for (int u = 0; u < 4; u++) begin
			wr(OFS_MODULE_CFG, 16'(u << MCFG_USTEP_LO));
			rd(OFS_POS_CYC_CH1, msk[u]);
		end
		wr(OFS_MODULE_CFG, 16'h0040);
		wr(OFS_MOTION_CTRL, 16'h0010);
		wr(OFS_MOTION_CTRL, 16'h0010);
		@(posedge clk_sys) enc_step <= 2'h1;
		wait_cyc(2);
		@(posedge clk_sys) enc_step <= 2'h2;
		enc_dir <= 2'h2;
		@(posedge clk_sys) enc_step <= 2'h0;
		wait_cyc(4);
		for (int w = 0; w < 3; w++) begin
			wr(OFS_COUNTER_CFG, w == 0 ? 16'h0000 : (w == 1 ? 16'h0008 : 16'h0088));
			rd(OFS_POS_CYC_CH1, w > 0 ? 16'h0003 : 16'hFFFE);
			rd(OFS_POS_ACYC_CH1, w > 0 ? 16'hFFFE : 16'h0003);
			rd(OFS_POS_CYC_CH2, w > 1 ? 16'hFFFF : 16'h0002);
			rd(OFS_POS_ACYC_CH2, w > 1 ? 16'h0002 : 16'hFFFF);
		end
		wr(OFS_MOTION_CTRL, 16'h0001);
		rd(OFS_POS_ACYC_CH1, 16'h0000);
		rd(OFS_COUNTER_CFG, 16'h0088);
		rd(OFS_MODULE_CFG, 16'h0040);
		rd(OFS_CURRENT_SEL, 16'h0A0E);
		complete_run();
	end
endmodule
